/* File: fsdfg_pkg.sv */
package fsdfg_pkg;
   localparam logic [19:0] DATA_FLASH_CONTROL_ADDR = 20'hf0090;
   localparam logic [7:0] DATA_FLASH_CONTROL_RESET = 8'h00;
   localparam int ENABLE_BIT = 0;
   localparam logic [19:0] BOOT0_LO = 20'h00000;
   localparam logic [19:0] BOOT0_HI = 20'h00fff;
   localparam int DF_BLOCK_BYTES = 1024;
   localparam int CLK_MHZ = 250;
   localparam int SETUP_TIME_US = 5;
   localparam int SETUP_CYCLES = SETUP_TIME_US * CLK_MHZ;
   localparam logic [11:0] SETUP_CYCLES_W = 12'(SETUP_CYCLES);
   localparam logic [2:0] PROT_RESET = 3'h0;

   typedef enum logic [1:0] {
      FSDFG_CMD_ERASE = 2'h0,
      FSDFG_CMD_WRITE = 2'h1,
      FSDFG_CMD_SET = 2'h2,
      FSDFG_CMD_RELEASE = 2'h3
   } fsdfg_cmd_type;

   typedef struct packed {
      logic erase_prot;
      logic write_prot;
      logic boot0_prot;
   } fsdfg_prot_type;

   typedef struct packed {
      logic valid;
      logic serial;
      fsdfg_cmd_type cmd;
      logic [19:0] addr;
      fsdfg_prot_type prot;
   } fsdfg_req_type;

   typedef enum logic [2:0] {
      FSDFG_DF_OFF = 3'b001,
      FSDFG_DF_SETUP = 3'b010,
      FSDFG_DF_READY = 3'b100
   } fsdfg_df_state_type;
endpackage

/* File: fsdfg_gate.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - Serial erase refused under erase prohibition.
// - Serial write refused under write prohibition.
// - Boot cluster 0 never rewritten when protected.
// - Shipped state has no protection active.
// - Settings independent, set from either mode.
// - Release takes effect only after reset.
// - Boot cluster 0 protection never cleared.
// - Self-set erase prohibition is permanent.
// - Write prohibition not cleared in self-programming.
// - Write release needs no others, blank flash.
// - Data flash erased in 1 KB blocks.
// - Data flash accessed only byte-wide.
// - No instruction fetch from data flash.
// - Code fetch continues during data flash rewrite.
// - Data flash blocked during code flash rewrite.
// - Control register writes ignored during data flash rewrite.
// - Stop refused during data flash rewrite.
// - Data flash stopped after reset.
// - Control register resets zero, only bit 0.
// - Access blocked for 5 us setup.
module fsdfg_gate (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire fsdfg_pkg::fsdfg_req_type req_i,
   input wire logic code_blank_i,
   input wire logic data_blank_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [19:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic df_acc_i,
   input wire logic df_fetch_i,
   input wire logic df_byte_i,
   input wire logic code_rewrite_i,
   input wire logic background_rewrite_i,
   input wire logic stop_req_i,
   output logic [7:0] reg_rdata_o,
   output logic req_accept_o,
   output logic req_reject_o,
   output logic [9:0] erase_base_o,
   output fsdfg_pkg::fsdfg_prot_type prot_o,
   output logic df_grant_o,
   output logic df_deny_o,
   output logic fetch_grant_o,
   output logic stop_grant_o,
   output logic df_ready_o
);
   fsdfg_pkg::fsdfg_prot_type prot_reg;
   fsdfg_pkg::fsdfg_prot_type prot_next;
   logic self_erase_reg;
   logic ctl_en_reg;
   logic [11:0] setup_cnt_reg;
   fsdfg_pkg::fsdfg_df_state_type df_state_reg;
   logic ok;
   logic release_ok;
   logic in_boot0;
   logic is_set;
   logic take_set;
   logic self_erase_set;
   logic ctl_sel;
   logic ctl_write;
   logic ctl_read;
   logic df_is_off;
   logic df_is_setup;
   logic df_is_ready;
   logic df_allow;
   logic stop_allow;

   // Boot cluster 0 starts at address zero, so only the upper bound is compared.
   assign in_boot0 = (req_i.addr <= fsdfg_pkg::BOOT0_HI);
   assign is_set = req_i.valid && (req_i.cmd == fsdfg_pkg::FSDFG_CMD_SET);
   assign take_set = is_set && ok;
   assign self_erase_set = take_set && !req_i.serial && req_i.prot.erase_prot;

   // A release is refused as a whole when any flag in it may not be cleared.
   always_comb begin
      release_ok = 1'b1;
      if (req_i.prot.boot0_prot) begin
         release_ok = 1'b0;
      end
      if (req_i.prot.erase_prot && (self_erase_reg || !req_i.serial)) begin
         release_ok = 1'b0;
      end
      if (req_i.prot.write_prot && !req_i.serial) begin
         release_ok = 1'b0;
      end
      if (req_i.prot.write_prot && (prot_reg.erase_prot || prot_reg.boot0_prot)) begin
         release_ok = 1'b0;
      end
      if (req_i.prot.write_prot && !(code_blank_i && data_blank_i)) begin
         release_ok = 1'b0;
      end
   end

   // Erase and write are checked against the flags now in force.
   always_comb begin
      ok = 1'b1;
      case (req_i.cmd)
         fsdfg_pkg::FSDFG_CMD_ERASE: begin
            if (req_i.serial && prot_reg.erase_prot) begin
               ok = 1'b0;
            end
            if (prot_reg.boot0_prot && in_boot0) begin
               ok = 1'b0;
            end
         end
         fsdfg_pkg::FSDFG_CMD_WRITE: begin
            if (req_i.serial && prot_reg.write_prot) begin
               ok = 1'b0;
            end
            if (prot_reg.boot0_prot && in_boot0) begin
               ok = 1'b0;
            end
         end
         fsdfg_pkg::FSDFG_CMD_SET: begin
            ok = 1'b1;
         end
         fsdfg_pkg::FSDFG_CMD_RELEASE: begin
            ok = release_ok;
         end
         default: begin
            ok = 1'b0;
         end
      endcase
   end

   always_comb begin
      prot_next = prot_reg;
      if (take_set) begin
         prot_next = prot_reg | req_i.prot;
      end
   end

   // An accepted release leaves the flags in force; only the next reset clears them.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prot_reg <= fsdfg_pkg::PROT_RESET;
      end else begin
         prot_reg <= prot_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         self_erase_reg <= 1'b0;
      end else if (self_erase_set) begin
         self_erase_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_accept_o <= 1'b0;
      end else begin
         req_accept_o <= req_i.valid && ok;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_reject_o <= 1'b0;
      end else begin
         req_reject_o <= req_i.valid && !ok;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         erase_base_o <= 10'h000;
      end else begin
         erase_base_o <= req_i.addr[19:10];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prot_o <= fsdfg_pkg::PROT_RESET;
      end else begin
         prot_o <= prot_reg;
      end
   end

   assign ctl_sel = (reg_addr_i == fsdfg_pkg::DATA_FLASH_CONTROL_ADDR);
   assign ctl_write = reg_wr_i && ctl_sel && !background_rewrite_i;
   assign ctl_read = reg_rd_i && ctl_sel;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_en_reg <= fsdfg_pkg::DATA_FLASH_CONTROL_RESET[fsdfg_pkg::ENABLE_BIT];
      end else if (ctl_write) begin
         ctl_en_reg <= reg_wdata_i[fsdfg_pkg::ENABLE_BIT];
      end
   end

   // Bits 7 to 1 are not implemented and always read as zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reg_rdata_o <= fsdfg_pkg::DATA_FLASH_CONTROL_RESET;
      end else if (ctl_read) begin
         reg_rdata_o <= {7'h00, ctl_en_reg};
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   assign df_is_off = (df_state_reg == fsdfg_pkg::FSDFG_DF_OFF);
   assign df_is_setup = (df_state_reg == fsdfg_pkg::FSDFG_DF_SETUP);
   assign df_is_ready = (df_state_reg == fsdfg_pkg::FSDFG_DF_READY);

   // The setup count is reloaded while the data flash is off.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         setup_cnt_reg <= 12'h000;
      end else if (df_is_off) begin
         setup_cnt_reg <= fsdfg_pkg::SETUP_CYCLES_W;
      end else if (df_is_setup && (setup_cnt_reg != 12'h001)) begin
         setup_cnt_reg <= setup_cnt_reg - 12'h001;
      end
   end

   // Data flash state: off, counting out the setup time, or ready.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         df_state_reg <= fsdfg_pkg::FSDFG_DF_OFF;
      end else begin
         case (df_state_reg)
            fsdfg_pkg::FSDFG_DF_OFF: begin
               if (ctl_en_reg) begin
                  df_state_reg <= fsdfg_pkg::FSDFG_DF_SETUP;
               end
            end
            fsdfg_pkg::FSDFG_DF_SETUP: begin
               if (!ctl_en_reg) begin
                  df_state_reg <= fsdfg_pkg::FSDFG_DF_OFF;
               end else if (setup_cnt_reg == 12'h001) begin
                  df_state_reg <= fsdfg_pkg::FSDFG_DF_READY;
               end
            end
            fsdfg_pkg::FSDFG_DF_READY: begin
               if (!ctl_en_reg) begin
                  df_state_reg <= fsdfg_pkg::FSDFG_DF_OFF;
               end
            end
            default: begin
               df_state_reg <= fsdfg_pkg::FSDFG_DF_OFF;
            end
         endcase
      end
   end

   assign df_allow = df_acc_i && df_byte_i && !df_fetch_i &&
                     !code_rewrite_i && df_is_ready;
   assign stop_allow = stop_req_i && !background_rewrite_i && !df_is_setup;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         df_grant_o <= 1'b0;
      end else begin
         df_grant_o <= df_allow;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         df_deny_o <= 1'b0;
      end else begin
         df_deny_o <= df_acc_i && !df_allow;
      end
   end

   // Code fetch never depends on the data flash, so it is always granted.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fetch_grant_o <= 1'b0;
      end else begin
         fetch_grant_o <= 1'b1;
      end
   end

   // Stop waits while a data flash rewrite or the setup time is running.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_grant_o <= 1'b0;
      end else begin
         stop_grant_o <= stop_allow;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         df_ready_o <= 1'b0;
      end else begin
         df_ready_o <= df_is_ready;
      end
   end
endmodule // fsdfg_gate
`default_nettype wire

/* File: fsdfg_gate_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module fsdfg_gate_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire fsdfg_pkg::fsdfg_req_type req_i,
   input wire logic reg_rd_i,
   input wire logic df_acc_i,
   input wire logic df_fetch_i,
   input wire logic df_byte_i,
   input wire logic code_rewrite_i,
   input wire logic background_rewrite_i,
   input wire logic stop_req_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic req_reject_o,
   input wire fsdfg_pkg::fsdfg_prot_type prot_o,
   input wire logic df_grant_o,
   input wire logic df_ready_o,
   input wire logic stop_grant_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic er;
   logic wr;
   assign er = req_i.valid && req_i.cmd == fsdfg_pkg::FSDFG_CMD_ERASE;
   assign wr = req_i.valid && req_i.cmd == fsdfg_pkg::FSDFG_CMD_WRITE;
   property p_ser_erase; er && req_i.serial && prot_o.erase_prot |=> req_reject_o; endproperty
   a_ser_erase: assert property (p_ser_erase) else $error("serial erase not refused");
   property p_ser_write; wr && req_i.serial && prot_o.write_prot |=> req_reject_o; endproperty
   a_ser_write: assert property (p_ser_write) else $error("serial write not refused");
   property p_boot0; (er || wr) && req_i.addr <= fsdfg_pkg::BOOT0_HI && prot_o.boot0_prot |=> req_reject_o; endproperty
   a_boot0: assert property (p_boot0) else $error("boot area rewrite not refused");
   property p_boot0_keep; prot_o.boot0_prot |=> prot_o.boot0_prot; endproperty
   a_boot0_keep: assert property (p_boot0_keep) else $error("boot area guard cleared");
   property p_release; req_i.valid && req_i.cmd == fsdfg_pkg::FSDFG_CMD_RELEASE |=> ##1 $stable(prot_o); endproperty
   a_release: assert property (p_release) else $error("release acted before reset");
   property p_df_kind; df_acc_i && (df_fetch_i || !df_byte_i) |=> !df_grant_o; endproperty
   a_df_kind: assert property (p_df_kind) else $error("fetch or wide access granted");
   property p_df_busy; (df_acc_i && code_rewrite_i |=> !df_grant_o) and (df_grant_o |-> df_ready_o); endproperty
   a_df_busy: assert property (p_df_busy) else $error("access granted while blocked");
   property p_stop; stop_req_i && background_rewrite_i |=> !stop_grant_o; endproperty
   a_stop: assert property (p_stop) else $error("stop granted during rewrite");
   property p_rd; reg_rd_i |=> reg_rdata_o[7:1] == 7'h00; endproperty
   a_rd: assert property (p_rd) else $error("unused control bits read nonzero");
   c_reject: cover property (req_reject_o);
   c_ready: cover property ($rose(df_ready_o));
   c_grant: cover property (df_grant_o);
endmodule // fsdfg_gate_asserts
bind fsdfg_gate fsdfg_gate_asserts chk_u (.clk_i, .rst_i, .req_i, .reg_rd_i, .df_acc_i, .df_fetch_i, .df_byte_i,
   .code_rewrite_i, .background_rewrite_i, .stop_req_i, .reg_rdata_o, .req_reject_o, .prot_o, .df_grant_o,
   .df_ready_o, .stop_grant_o);
`default_nettype wire

/* File: fsdfg_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Command source of the programmer or the self-programming code; it shows each command one clock later.
module fsdfg_host (
   input wire logic clk_i,
   input wire fsdfg_pkg::fsdfg_req_type cmd_i,
   output var fsdfg_pkg::fsdfg_req_type req_o
);
   always_ff @(posedge clk_i) begin
      req_o <= cmd_i;
   end
endmodule // fsdfg_host
`default_nettype wire

/* File: flash_security_and_data_flash_gate_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("BAD %0t got %h", $time, a); end end
module flash_security_and_data_flash_gate_test;
   localparam logic [19:0] A = fsdfg_pkg::DATA_FLASH_CONTROL_ADDR;
   logic clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, df_acc_i = 0, df_fetch_i = 0, df_byte_i = 1;
   logic code_blank_i = 1, data_blank_i = 1, code_rewrite_i = 0, background_rewrite_i = 0, stop_req_i = 0;
   logic [19:0] reg_addr_i = 20'h00000, hi, lo;
   logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
   logic [9:0] erase_base_o;
   logic req_accept_o, req_reject_o, df_grant_o, df_deny_o, fetch_grant_o, stop_grant_o, df_ready_o;
   logic [1:0] e;
   logic [1:0] exp_q[$];
   fsdfg_pkg::fsdfg_req_type cmd_q = '0, req_i;
   fsdfg_pkg::fsdfg_prot_type prot_o;
   int fails = 0, checks_done = 0, n;
   fsdfg_host host_u (.clk_i, .cmd_i(cmd_q), .req_o(req_i));
   fsdfg_gate dut_u (.clk_i, .rst_i, .req_i, .code_blank_i, .data_blank_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
      .reg_wdata_i, .df_acc_i, .df_fetch_i, .df_byte_i, .code_rewrite_i, .background_rewrite_i, .stop_req_i,
      .reg_rdata_o, .req_accept_o, .req_reject_o, .erase_base_o, .prot_o, .df_grant_o, .df_deny_o, .fetch_grant_o,
      .stop_grant_o, .df_ready_o);
   initial forever #2 clk_i = ~clk_i;
   task automatic tick;
      @(posedge clk_i) #1;
   endtask
   task automatic cmd(input logic s, input logic [1:0] c, input logic [19:0] a, input logic [2:0] p, input logic [1:0] x);
      tick();
      cmd_q = {1'b1, s, c, a, p};
      exp_q.push_back(x);
      tick();
      cmd_q.valid = 1'b0;
      repeat (2) tick();
   endtask
   task automatic reg_op(input logic w, input logic [7:0] d);
      tick();
      reg_wr_i = w;
      reg_rd_i = ~w;
      reg_wdata_i = d;
      tick();
      reg_wr_i = 0;
      reg_rd_i = 0;
      if (!w) `CHK(reg_rdata_o, d)
   endtask
   task automatic df(input logic f, input logic b, input logic g);
      tick();
      df_acc_i = 1;
      df_fetch_i = f;
      df_byte_i = b;
      tick();
      df_acc_i = 0;
      `CHK({df_grant_o, df_deny_o}, {g, ~g})
   endtask
   task automatic reset;
      rst_i = 1;
      repeat (10) tick();
      rst_i = 0;
      tick();
      `CHK(prot_o, 3'h0)
   endtask
   task automatic summarize;
      if (exp_q.size() != 0) fails++;
      $display("checks_done %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(negedge clk_i) begin
      if (req_accept_o === 1'b1 || req_reject_o === 1'b1) begin
         e = exp_q.pop_front();
         `CHK({req_accept_o, req_reject_o}, e)
      end
   end
   initial begin
      #80000;
      fails++;
      summarize();
   end
   initial begin
      n = $urandom(32'h3a56);
      hi = 20'h01000 + 20'($urandom % 32'h7f000);
      lo = 20'($urandom % 32'h1000);
      reset();
      reg_addr_i = A;
      reg_op(0, 8'h00);
      df(0, 1, 0);
      cmd(1, 0, hi, 3'h0, 2'b10);
      `CHK(erase_base_o, hi[19:10])
      cmd(1, 2, hi, 3'h4, 2'b10);
      cmd(0, 2, hi, 3'h2, 2'b10);
      `CHK(prot_o, 3'h6)
      cmd(1, 0, hi, 3'h0, 2'b01);
      cmd(0, 0, hi, 3'h0, 2'b10);
      cmd(1, 1, hi, 3'h0, 2'b01);
      cmd(0, 1, hi, 3'h0, 2'b10);
      cmd(0, 3, hi, 3'h2, 2'b01);
      cmd(1, 3, hi, 3'h2, 2'b01);
      cmd(0, 2, lo, 3'h1, 2'b10);
      cmd(0, 0, lo, 3'h0, 2'b01);
      cmd(0, 1, lo, 3'h0, 2'b01);
      cmd(1, 3, lo, 3'h1, 2'b01);
      `CHK(prot_o, 3'h7)
      reset();
      cmd(0, 2, hi, 3'h4, 2'b10);
      cmd(1, 3, hi, 3'h4, 2'b01);
      reset();
      cmd(1, 2, hi, 3'h2, 2'b10);
      code_blank_i = 0;
      cmd(1, 3, hi, 3'h2, 2'b01);
      code_blank_i = 1;
      cmd(1, 3, hi, 3'h2, 2'b10);
      `CHK(prot_o, 3'h2)
      reset();
      reg_op(1, 8'($urandom) | 8'h01);
      df(0, 1, 0);
      n = 2;
      while (df_ready_o !== 1'b1 && n < 1400) begin
         tick();
         n++;
      end
      `CHK(n >= 1250 && n <= 1253, 1'b1)
      df(0, 1, 1);
      df(1, 1, 0);
      df(0, 0, 0);
      code_rewrite_i = 1;
      df(0, 1, 0);
      code_rewrite_i = 0;
      reg_op(0, 8'h01);
      reg_addr_i = A + 20'h00001;
      reg_op(0, 8'h00);
      reg_addr_i = A;
      background_rewrite_i = 1;
      stop_req_i = 1;
      repeat (2) tick();
      `CHK(stop_grant_o, 1'b0)
      `CHK(fetch_grant_o, 1'b1)
      stop_req_i = 0;
      reg_op(1, 8'h00);
      reg_op(0, 8'h01);
      background_rewrite_i = 0;
      stop_req_i = 1;
      repeat (2) tick();
      `CHK(stop_grant_o, 1'b1)
      reg_op(1, 8'h00);
      reg_op(1, 8'h01);
      repeat (2) tick();
      `CHK(stop_grant_o, 1'b0)
      reg_op(1, 8'h00);
      repeat (2) tick();
      `CHK(stop_grant_o, 1'b1)
      stop_req_i = 0;
      summarize();
   end
endmodule // flash_security_and_data_flash_gate_test
`default_nettype wire
